/* File: bench/lpd_monitor.sv */
// Purpose: concurrent checks on the detector scan block ports
// Assumes: one clock domain, asynchronous active high reset
// Notes: fault pins pass a synchroniser, so fault checks wait for five stable cycles
module lpd_monitor #(
  parameter int RETUNE_CYC = 50 // retune length in cycles
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // watched inputs
  input wire lpd_pkg::lpd_pins_s pins_in,
  input wire logic [lpd_pkg::N_PIEZO-1:0][lpd_pkg::PZ_W-1:0] piezo_in,
  input wire logic [lpd_pkg::PZ_W-1:0] pz_thr_hi_in,
  // watched outputs
  input wire logic [lpd_pkg::N_LOOPS-1:0] loop_sel_out,
  input wire logic [lpd_pkg::N_LOOPS-1:0] loop_act_out,
  input wire logic [lpd_pkg::N_LOOPS-1:0] loop_open_out,
  input wire logic [lpd_pkg::N_LOOPS-1:0] loop_short_out,
  input wire logic retuning_out,
  input wire logic [lpd_pkg::N_PIEZO-1:0] piezo_det_out,
  input wire logic [lpd_pkg::N_LANES-1:0] lane_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking mon_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  int hold_ff; // cycles the current selection has stood
  int rt_ff; // cycles retuning has been high
  logic [lpd_pkg::N_LOOPS-1:0] prev_ff; // selection seen last cycle
  logic [lpd_pkg::N_LOOPS-1:0] bad; // loops with either fault
  logic [lpd_pkg::N_LANES-1:0] lane_exp; // lane lost only when both loops are bad

  // helper counters, cleared by reset so a second reset starts clean
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hold_ff <= 0;
      rt_ff <= 0;
      prev_ff <= '0;
    end else begin
      hold_ff <= (loop_sel_out != prev_ff) ? 0 : hold_ff + 1;
      rt_ff <= retuning_out ? rt_ff + 1 : 0;
      prev_ff <= loop_sel_out;
    end
  end

  // expected lane health from the fault outputs
  always_comb begin
    bad = loop_open_out | loop_short_out;
    for (int j = 0; j < lpd_pkg::N_LANES; j++) begin
      lane_exp[j] = !(bad[2*j] && bad[2*j+1]);
    end
  end

  chk_sel_onehot: assert property ($onehot0(loop_sel_out))
    else $error("loop select not one-hot");
  chk_sel_dwell: assert property (($changed(loop_sel_out) && $past(loop_sel_out) != 0 && loop_sel_out != 0)
    |-> hold_ff == 2999) else $error("loop dwell not 3000 cycles");
  chk_act_rise: assert property ((loop_act_out & ~$past(loop_act_out) & ~$past(loop_sel_out)) == 0)
    else $error("actuation rose on an unselected loop");
  chk_fault_follow: assert property ($stable({pins_in.open_ckt, pins_in.short_ckt})[*5]
    |-> {loop_open_out, loop_short_out} == {pins_in.open_ckt, pins_in.short_ckt}) else $error("fault outputs stale");
  chk_retune_len: assert property ($fell(retuning_out) |-> rt_ff >= RETUNE_CYC - 1 && rt_ff <= RETUNE_CYC + 1)
    else $error("retune length wrong");
  chk_pz_single: assert property (piezo_det_out != 0 |=> (piezo_det_out & $past(piezo_det_out)) == 0)
    else $error("piezo pulse longer than one cycle");
  chk_lane_health: assert property (!$past(rst_in) && $stable(bad) |-> lane_ok_out == lane_exp)
    else $error("lane health wrong");
  for (genvar i = 0; i < lpd_pkg::N_PIEZO; i++) begin : g_pz
    chk_pz_cause: assert property (piezo_det_out[i] |-> $past(piezo_in[i]) > $past(pz_thr_hi_in))
      else $error("piezo detection without high sample");
  end

  // main scenarios reached
  cover property ($rose(loop_act_out[0]));
  cover property ($fell(retuning_out));
  cover property (piezo_det_out == 8'hFF);
endmodule : lpd_monitor

bind lpd_top lpd_monitor #(.RETUNE_CYC(RETUNE_CYC)) mon_u (.clock_in, .rst_in, .pins_in, .piezo_in, .pz_thr_hi_in,
  .loop_sel_out, .loop_act_out, .loop_open_out, .loop_short_out, .retuning_out, .piezo_det_out, .lane_ok_out);

/* File: bench/lpd_road.sv */
// Purpose: road side model, loop oscillator counts and piezo samples
// Assumes: a count is only meaningful while its loop is selected
// Notes: with no loop selected the count wanders so a stale read never matches
module lpd_road (
  // clock
  input wire logic clock_in,
  // selection, vehicle presence and axle hits
  input wire logic [lpd_pkg::N_LOOPS-1:0] loop_sel_in,
  input wire logic [lpd_pkg::N_LOOPS-1:0][lpd_pkg::CNT_W-1:0] delta_in,
  input wire logic [lpd_pkg::N_PIEZO-1:0] hit_in,
  // sensor outputs
  output logic [lpd_pkg::CNT_W-1:0] count_out,
  output logic [lpd_pkg::N_PIEZO-1:0][lpd_pkg::PZ_W-1:0] piezo_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [lpd_pkg::CNT_W-1:0] wander = 16'h5A5A; // idle oscillator noise

  // noise moves every cycle
  always @(posedge clock_in) begin
    wander <= wander + 16'h1357;
  end

  // eight loops and eight piezos, all piezos answer at once
  always_comb begin
    count_out = wander;
    for (int i = 0; i < lpd_pkg::N_PIEZO; i++) begin
      if (loop_sel_in[i]) begin
        count_out = 16'h4000 + delta_in[i];
      end
      piezo_out[i] = hit_in[i] ? 12'h12C : 12'h032;
    end
  end
endmodule : lpd_road

/* File: bench/lpd_top_bench.sv */
// Purpose: self-checking bench for the loop scanner, piezo detector and panel indicators
// Assumes: retune shortened to just over one full scan, indicator tick of 20 cycles
// Notes: inputs change by non-blocking assignment on the rising edge, checks 1 ns later except the two piezo count checks
module lpd_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MEAS = lpd_pkg::MEAS_CYC; // one loop dwell
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  lpd_pkg::lpd_pins_s pins_in = '0;
  logic [7:0] ovr_en_in = '0, con_en_in = '0, ovr_sens_in = '0, con_sens_high_in = '0;
  logic [15:0] loop_count_in;
  logic [7:0][15:0] delta = '0; // per loop inductance change
  logic [7:0] hit = '0; // axle on piezo
  logic [7:0][11:0] piezo_in;
  logic [11:0] pz_thr_hi_in = 12'h0C8, pz_thr_lo_in = 12'h064;
  logic pz_timeout_en_in = 1'b0;
  logic [7:0] pz_timeout_in = 8'hFF;
  lpd_pkg::lpd_cfg_e sensor_cfg_in = lpd_pkg::CFG_LL;
  logic ctrl_ok_in = 1'b1, rx_msg_in = 1'b0, tx_msg_in = 1'b0, retuning_out, h;
  logic [3:0] vehicle_sent_in = '0, lane_occ_out, lane_ok_out;
  logic [7:0] loop_sel_out, loop_act_out, loop_open_out, loop_short_out, piezo_det_out;
  lpd_pkg::lpd_leds_s leds_out;
  int n_fail = 0, comparisons = 0, det0 = 0, c0, n;

  lpd_top #(.RETUNE_CYC(24500), .TICK_CYC(20)) dut_u (.clock_in, .rst_in, .pins_in, .ovr_en_in, .con_en_in,
    .ovr_sens_in, .con_sens_high_in, .loop_count_in, .loop_sel_out, .piezo_in, .pz_thr_hi_in, .pz_thr_lo_in,
    .pz_timeout_en_in, .pz_timeout_in, .sensor_cfg_in, .ctrl_ok_in, .vehicle_sent_in, .rx_msg_in, .tx_msg_in,
    .loop_act_out, .loop_open_out, .loop_short_out, .retuning_out, .piezo_det_out, .lane_occ_out,
    .lane_ok_out, .leds_out);
  lpd_road road_u (.clock_in, .loop_sel_in(loop_sel_out), .delta_in(delta), .hit_in(hit),
    .count_out(loop_count_in), .piezo_out(piezo_in));

  // 10 MHz clock
  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // count detections on channel 0
  always @(posedge clock_in) begin
    if (piezo_det_out[0] === 1'b1) det0++;
  end

  task automatic tick(input int cycles);
    repeat (cycles) @(posedge clock_in);
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic do_reset;
    rst_in <= 1'b1;
    tick(4);
    rst_in <= 1'b0;
  endtask : do_reset

  // selection order and dwell over the enabled loops, with wrap
  task automatic scan_check(input logic [7:0] mask, input int steps);
    int k = 0;
    for (int i = 0; i < 40 && loop_sel_out === 8'h00; i++) tick(1);
    tick(1);
    #1;
    for (int s = 0; s < steps; s++) begin
      while (!mask[k]) k = (k + 1) % 8;
      chk(16'(loop_sel_out), 16'(8'h01 << k), "loop select");
      k = (k + 1) % 8;
      tick(MEAS);
      #1;
    end
  endtask : scan_check

  // axle pulse train, each level held past one sample interval
  task automatic pz_train(input int pulses);
    repeat (pulses) begin
      tick(1);
      hit <= 8'h00;
      tick(1500);
      hit <= 8'hFF;
      tick(1500);
    end
  endtask : pz_train

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    do_reset();
    pins_in.en_sw <= 8'hFF;
    pins_in.sens_sw <= 8'h03;
    ovr_sens_in <= 8'h10;
    con_sens_high_in <= 8'h10;
    scan_check(8'hFF, 9);
    chk(16'(retuning_out), 16'h0000, "retune end");
    tick(1);
    delta <= {16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0071, 16'h0070, 16'h0050, 16'h0051};
    tick(8 * MEAS);
    #1;
    chk(16'(loop_act_out), 16'h0019, "actuation");
    tick(1);
    pins_in.open_ckt <= 8'h04;
    pins_in.short_ckt <= 8'h08;
    tick(6);
    #1;
    chk({loop_open_out, loop_short_out}, 16'h0408, "faults");
    chk({lane_ok_out, lane_occ_out}, 8'hD5, "lane health");
    chk(16'(leds_out.sensor_indicators & 8'hF3), 16'h0011, "loop leds");
    h = leds_out.sensor_indicators[2];
    tick(20);
    #1;
    chk(16'(leds_out.sensor_indicators[2]), 16'(!h), "fault blink");
    tick(1);
    pins_in.open_ckt <= 8'h00;
    pins_in.short_ckt <= 8'h00;
    for (int c = 0; c < 5; c++) begin
      tick(6);
      sensor_cfg_in <= lpd_pkg::lpd_cfg_e'(c);
      tick(4);
      #1;
      chk(16'({leds_out.sensor_indicators, leds_out.lane_indicators}), c < 3 ? 16'h0190 : 16'(c == 4 ? 5 : 0),
        "indicator map");
    end
    tick(1);
    sensor_cfg_in <= lpd_pkg::CFG_LL;
    vehicle_sent_in <= 4'h2;
    rx_msg_in <= 1'b1;
    tx_msg_in <= 1'b1;
    tick(1);
    vehicle_sent_in <= 4'h0;
    rx_msg_in <= 1'b0;
    tx_msg_in <= 1'b0;
    tick(3);
    #1;
    chk({leds_out.lane_indicators, leds_out.rx_indicator, leds_out.tx_indicator}, 16'h000B, "flash on");
    tick(60);
    #1;
    chk({leds_out.lane_indicators, leds_out.rx_indicator, leds_out.tx_indicator}, 16'h0000, "flash off");
    // sync to a heartbeat edge first so the next half period is counted whole
    h = leds_out.heartbeat_indicator;
    for (int i = 0; i < 200 && leds_out.heartbeat_indicator === h; i++) begin tick(1); #1; end
    h = leds_out.heartbeat_indicator;
    for (n = 0; n < 200 && leds_out.heartbeat_indicator === h; n++) begin tick(1); #1; end
    chk(16'(n), 16'h0064, "heartbeat half period");
    tick(1);
    ctrl_ok_in <= 1'b0;
    pins_in.retune_btn <= 1'b1;
    tick(4);
    pins_in.retune_btn <= 1'b0;
    tick(2);
    #1;
    chk({15'h0000, retuning_out}, 16'h0001, "retune start");
    chk(16'({leds_out.power_indicator, leds_out.heartbeat_indicator}), 16'h0002, "heartbeat stopped");
    tick(1);
    sensor_cfg_in <= lpd_pkg::CFG_PP;
    hit <= 8'hFF;
    for (int i = 0; i < 1100 && piezo_det_out === 8'h00; i++) begin tick(1); #1; end
    chk(16'(piezo_det_out), 16'h00FF, "piezo all at once");
    tick(1);
    #1;
    chk(16'(piezo_det_out), 16'h0000, "piezo pulse end");
    tick(2);
    #1;
    chk(16'(leds_out.sensor_indicators), 16'h00FF, "piezo flash on");
    tick(60);
    #1;
    chk(16'(leds_out.sensor_indicators), 16'h0000, "piezo flash off");
    c0 = det0;
    pz_train(3);
    chk(16'(det0 - c0), 16'h0003, "hysteresis re-arm");
    pz_timeout_en_in <= 1'b1;
    c0 = det0;
    pz_train(3);
    chk(16'(det0 - c0), 16'h0001, "timeout window");
    for (int i = 0; i < 30000 && retuning_out !== 1'b0; i++) tick(1);
    #1;
    chk(16'(loop_act_out), 16'h0000, "all loops retuned");
    tick(1);
    ovr_en_in <= 8'hFF;
    con_en_in <= 8'h5A;
    do_reset();
    scan_check(8'h5A, 5);
    final_report();
  end

  // hang guard, a little past the expected run length of about 9.1 ms
  initial begin
    #9_800_000;
    n_fail++;
    final_report();
  end
endmodule : lpd_top_bench

/* File: design/lpd_pkg.sv */
// Purpose: shared constants and types for the loop and piezo detector scan block
// Assumes: 10 MHz clock, eight loops, eight piezo channels, four lanes
// Notes: every timing figure is kept in its own unit and converted here, to cycles or to indicator ticks
package lpd_pkg;

  // sizes of the sensor set
  localparam int N_LOOPS = 8;
  localparam int N_PIEZO = 8;
  localparam int N_LANES = 4;
  localparam int CNT_W = 16; // loop oscillator count width
  localparam int PZ_W = 12; // piezo sample width
  localparam int HOLD_W = 8; // piezo timeout window width, in 100 us steps

  // clock rate
  localparam longint CLK_HZ = 10_000_000;

  // loop dwell: one measurement per loop
  localparam int MEAS_TIME_US = 300;
  localparam int MEAS_CYC = int'((MEAS_TIME_US * CLK_HZ + 999_999) / 1_000_000);

  // piezo sampling interval, all channels at once
  localparam int PIEZO_TIME_US = 100;
  localparam int PIEZO_CYC = int'((PIEZO_TIME_US * CLK_HZ) / 1_000_000);

  // retune duration
  localparam int RETUNE_TIME_MS = 50;
  localparam int RETUNE_CYC_DEF = int'((RETUNE_TIME_MS * CLK_HZ + 999) / 1000);

  // indicator timebase: one tick per flash step
  localparam int FLASH_TIME_MS = 100;
  localparam int TICK_CYC_DEF = int'((FLASH_TIME_MS * CLK_HZ) / 1000);
  localparam int HB_PERIOD_MS = 1000;
  localparam logic [2:0] HB_HALF_TICKS = 3'(HB_PERIOD_MS / (2 * FLASH_TIME_MS));
  localparam logic [1:0] FLASH_TICKS = 2'h2; // length of one flash, in ticks

  // sensitivity levels and threshold scaling
  localparam logic [3:0] SENS_HIGH = 4'hA; // level 10
  localparam logic [3:0] SENS_LOW = 4'h8; // level 8
  localparam logic [3:0] SENS_SPAN = 4'hF;
  localparam logic [15:0] THR_UNIT = 16'h0010;

  // sensor configuration of the lanes
  typedef enum logic [2:0] {
    CFG_LL = 3'h0,
    CFG_LPL = 3'h1,
    CFG_LPPL = 3'h2,
    CFG_PP = 3'h3,
    CFG_PLP = 3'h4
  } lpd_cfg_e;

  // loop scanner states, gray along idle, dwell, evaluate
  typedef enum logic [1:0] {
    SC_IDLE = 2'h0,
    SC_DWELL = 2'h1,
    SC_EVAL = 2'h3
  } lpd_scan_e;

  // front panel switches and loop fault pins
  typedef struct packed {
    logic [N_LOOPS-1:0] en_sw; // high when switched right
    logic [N_LOOPS-1:0] sens_sw; // high when switched right
    logic [N_LOOPS-1:0] open_ckt;
    logic [N_LOOPS-1:0] short_ckt;
    logic retune_btn;
  } lpd_pins_s;

  // front panel indicators
  typedef struct packed {
    logic power_indicator;
    logic heartbeat_indicator;
    logic rx_indicator;
    logic tx_indicator;
    logic [N_LOOPS-1:0] sensor_indicators;
    logic [N_LANES-1:0] lane_indicators;
  } lpd_leds_s;

endpackage : lpd_pkg

/* File: design/lpd_top.sv */
// Purpose: loop scanner, piezo axle detector and front panel indicator logic
// Assumes: loop counts and piezo samples come from logic on the same clock
// Notes: switches and fault pins are asynchronous and pass two flip-flops

// Notes on behaviour
// (R01) four lanes, eight loops, eight piezos
// (R02) loops measured in turn, 300 us each
// (R03) scan period scales with enabled loops
// (R04) actuation when change exceeds sensitivity threshold
// (R05) sensitivity switch: right 10, left 8
// (R06) enable switch, console may override
// (R07) retune button retunes all loops, 50 ms
// (R08) open and short fault per loop reported
// (R09) all piezo channels evaluated together
// (R10) piezo threshold with hysteresis, optional timeout
// (R11) indicator mapping follows sensor configuration
// (R12) loop indicator lit, off, or flashing fault
// (R13) piezo indicator flashes on each detection
// (R14) lane indicator flashes on valid vehicle
// (R15) heartbeat flashes once per second running
// (R16) receive and transmit indicators flash per message
// (R17) lane keeps working on one loop
// (R18) scanner skips disabled loops round robin
module lpd_top #(
  parameter int RETUNE_CYC = lpd_pkg::RETUNE_CYC_DEF, // retune length in cycles
  parameter int TICK_CYC = lpd_pkg::TICK_CYC_DEF // indicator tick in cycles
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // asynchronous panel switches and loop fault pins
  input wire lpd_pkg::lpd_pins_s pins_in,
  // console overrides
  input wire logic [lpd_pkg::N_LOOPS-1:0] ovr_en_in,
  input wire logic [lpd_pkg::N_LOOPS-1:0] con_en_in,
  input wire logic [lpd_pkg::N_LOOPS-1:0] ovr_sens_in,
  input wire logic [lpd_pkg::N_LOOPS-1:0] con_sens_high_in,
  // loop oscillator
  input wire logic [lpd_pkg::CNT_W-1:0] loop_count_in,
  output logic [lpd_pkg::N_LOOPS-1:0] loop_sel_out,
  // piezo front end
  input wire logic [lpd_pkg::N_PIEZO-1:0][lpd_pkg::PZ_W-1:0] piezo_in,
  input wire logic [lpd_pkg::PZ_W-1:0] pz_thr_hi_in,
  input wire logic [lpd_pkg::PZ_W-1:0] pz_thr_lo_in,
  input wire logic pz_timeout_en_in,
  input wire logic [lpd_pkg::HOLD_W-1:0] pz_timeout_in,
  // configuration and supervisor events
  input wire lpd_pkg::lpd_cfg_e sensor_cfg_in,
  input wire logic ctrl_ok_in,
  input wire logic [lpd_pkg::N_LANES-1:0] vehicle_sent_in,
  input wire logic rx_msg_in,
  input wire logic tx_msg_in,
  // results
  output logic [lpd_pkg::N_LOOPS-1:0] loop_act_out,
  output logic [lpd_pkg::N_LOOPS-1:0] loop_open_out,
  output logic [lpd_pkg::N_LOOPS-1:0] loop_short_out,
  output logic retuning_out,
  output logic [lpd_pkg::N_PIEZO-1:0] piezo_det_out,
  output logic [lpd_pkg::N_LANES-1:0] lane_occ_out,
  output logic [lpd_pkg::N_LANES-1:0] lane_ok_out,
  // indicators
  output lpd_pkg::lpd_leds_s leds_out
);

  localparam int NL = lpd_pkg::N_LOOPS;
  localparam int NP = lpd_pkg::N_PIEZO;
  localparam int NN = lpd_pkg::N_LANES;

  // elaboration checks on loops per lane and on the counts the counters can hold
  if (NL != 2 * NN) begin : g_chk_lanes // R01
    $error("two loops per lane expected");
  end
  if (lpd_pkg::MEAS_CYC < 2 || lpd_pkg::MEAS_CYC > 4096) begin : g_chk_meas
    $error("loop dwell out of range");
  end
  if (RETUNE_CYC < 1 || RETUNE_CYC >= (1 << 20)) begin : g_chk_ret
    $error("retune count out of range");
  end
  if (TICK_CYC < 1 || TICK_CYC >= (1 << 20)) begin : g_chk_tick
    $error("tick count out of range");
  end

  // cycle limits at counter width
  localparam logic [11:0] MEAS_LAST = 12'(lpd_pkg::MEAS_CYC - 2);
  localparam logic [9:0] PZ_LAST = 10'(lpd_pkg::PIEZO_CYC - 1);
  localparam logic [19:0] RET_LAST = 20'(RETUNE_CYC - 1);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

  // complete module state
  typedef struct packed {
    lpd_pkg::lpd_pins_s s1; // first sync stage, read only by s2
    lpd_pkg::lpd_pins_s s2;
    logic btn_prev;
    logic retuning;
    logic [19:0] ret_cnt;
    lpd_pkg::lpd_scan_e scan;
    logic [2:0] cur;
    logic [11:0] dwell;
    logic [NL-1:0] sel;
    logic [NL-1:0][lpd_pkg::CNT_W-1:0] base;
    logic [NL-1:0] act;
    logic [9:0] pz_cnt;
    logic [NP-1:0] pz_on;
    logic [NP-1:0][lpd_pkg::HOLD_W-1:0] pz_hold;
    logic [NP-1:0] pz_det;
    logic [19:0] tick_cnt;
    logic blink;
    logic [2:0] hb_cnt;
    logic hb;
    logic [NP-1:0][1:0] pz_fl;
    logic [NN-1:0][1:0] vv_fl;
    logic [1:0] rx_fl;
    logic [1:0] tx_fl;
    lpd_pkg::lpd_leds_s leds;
    logic [NN-1:0] lane_occ;
    logic [NN-1:0] lane_ok;
  } lpd_state_s;

  lpd_state_s st_ff;
  lpd_state_s nxt_st;

  // next enabled loop after the current one, wrapping round
  function automatic logic [3:0] next_loop(input logic [NL-1:0] en, input logic [2:0] cur);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    idx = cur;
    for (int k = 1; k <= NL; k++) begin
      idx = 3'(cur + 3'(k));
      if (en[idx] && !res[3]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : next_loop

  // actuation threshold: higher sensitivity gives a smaller threshold
  function automatic logic [15:0] loop_thr(input logic high);
    logic [3:0] lvl;
    logic [15:0] span;
    lvl = high ? lpd_pkg::SENS_HIGH : lpd_pkg::SENS_LOW;
    span = {12'h000, 4'(lpd_pkg::SENS_SPAN - lvl)};
    return 16'(span * lpd_pkg::THR_UNIT);
  endfunction : loop_thr

  // flash stretcher: a new event reloads even in a tick cycle
  function automatic logic [1:0] flash(input logic ev, input logic tick, input logic [1:0] fl);
    logic [1:0] r;
    r = fl;
    if (ev) begin
      r = lpd_pkg::FLASH_TICKS;
    end else if (tick && fl != 2'h0) begin
      r = 2'(fl - 2'h1);
    end
    return r;
  endfunction : flash

  // next state of everything
  always_comb begin
    logic [NL-1:0] en_eff;
    logic [NL-1:0] sens_hi;
    logic [NL-1:0] fault;
    logic [NL-1:0] loop_led;
    logic [NP-1:0] pz_led;
    logic [3:0] nl;
    logic [lpd_pkg::CNT_W-1:0] delta;
    logic pz_tick;
    logic tick;
    en_eff = '0;
    sens_hi = '0;
    fault = '0;
    loop_led = '0;
    pz_led = '0;
    nl = 4'h0;
    delta = '0;
    pz_tick = 1'b0;
    tick = 1'b0;
    nxt_st = st_ff;

    // two-stage synchroniser for all panel pins
    nxt_st.s1 = pins_in;
    nxt_st.s2 = st_ff.s1;

    // console overrides win over the switches
    en_eff = (ovr_en_in & con_en_in) | (~ovr_en_in & st_ff.s2.en_sw); // R06
    sens_hi = (ovr_sens_in & con_sens_high_in) | (~ovr_sens_in & st_ff.s2.sens_sw); // R05
    fault = st_ff.s2.open_ckt | st_ff.s2.short_ckt; // R08

    // retune timer; a press during retune restarts it
    nxt_st.btn_prev = st_ff.s2.retune_btn;
    if (st_ff.retuning) begin
      if (st_ff.ret_cnt == RET_LAST) begin
        nxt_st.retuning = 1'b0; // R07
      end else begin
        nxt_st.ret_cnt = 20'(st_ff.ret_cnt + 20'h1);
      end
    end
    if (st_ff.s2.retune_btn && !st_ff.btn_prev) begin
      nxt_st.retuning = 1'b1; // R07
      nxt_st.ret_cnt = 20'h0;
    end

    // loop scanner: one loop at a time, only enabled loops
    nl = next_loop(en_eff, st_ff.cur); // R18
    case (st_ff.scan)
      lpd_pkg::SC_IDLE: begin
        if (nl[3]) begin
          nxt_st.cur = nl[2:0];
          nxt_st.sel = NL'(1) << nl[2:0]; // R02
          nxt_st.dwell = 12'h000;
          nxt_st.scan = lpd_pkg::SC_DWELL;
        end
      end
      lpd_pkg::SC_DWELL: begin
        // dwell plus the evaluate cycle make one full measurement
        if (st_ff.dwell == MEAS_LAST) begin
          nxt_st.scan = lpd_pkg::SC_EVAL; // R02
        end else begin
          nxt_st.dwell = 12'(st_ff.dwell + 12'h001);
        end
      end
      lpd_pkg::SC_EVAL: begin
        if (st_ff.retuning || fault[st_ff.cur]) begin
          // retune takes the present count as the new reference
          nxt_st.base[st_ff.cur] = loop_count_in; // R07
          nxt_st.act[st_ff.cur] = 1'b0;
        end else begin
          // a vehicle raises the oscillator count above the reference
          if (loop_count_in > st_ff.base[st_ff.cur]) begin
            delta = loop_count_in - st_ff.base[st_ff.cur];
          end
          nxt_st.act[st_ff.cur] = delta > loop_thr(sens_hi[st_ff.cur]); // R04
        end
        // period shrinks because only enabled loops are visited
        if (nl[3]) begin
          nxt_st.cur = nl[2:0]; // R03
          nxt_st.sel = NL'(1) << nl[2:0];
          nxt_st.dwell = 12'h000;
          nxt_st.scan = lpd_pkg::SC_DWELL;
        end else begin
          nxt_st.sel = '0;
          nxt_st.scan = lpd_pkg::SC_IDLE;
        end
      end
      default: begin
        nxt_st.sel = '0;
        nxt_st.scan = lpd_pkg::SC_IDLE;
      end
    endcase
    // a loop switched off drops its actuation at once
    nxt_st.act = nxt_st.act & en_eff; // R18

    // piezo sample interval
    pz_tick = st_ff.pz_cnt == PZ_LAST;
    nxt_st.pz_cnt = pz_tick ? 10'h000 : 10'(st_ff.pz_cnt + 10'h001);
    nxt_st.pz_det = '0;
    // every channel compared in the same cycle
    for (int c = 0; c < NP; c++) begin
      if (pz_tick) begin
        if (st_ff.pz_hold[c] != '0) begin
          nxt_st.pz_hold[c] = st_ff.pz_hold[c] - {{(lpd_pkg::HOLD_W-1){1'b0}}, 1'b1}; // R10
        end
        if (!st_ff.pz_on[c] && piezo_in[c] > pz_thr_hi_in) begin
          nxt_st.pz_on[c] = 1'b1; // R10
          // timeout window swallows re-triggers on the same channel
          if (st_ff.pz_hold[c] == '0) begin
            nxt_st.pz_det[c] = 1'b1; // R09
            if (pz_timeout_en_in) begin
              nxt_st.pz_hold[c] = pz_timeout_in; // R10
            end
          end
        end else if (st_ff.pz_on[c] && piezo_in[c] < pz_thr_lo_in) begin
          nxt_st.pz_on[c] = 1'b0; // R10
        end
      end
    end

    // indicator timebase and slow blink for faults
    tick = st_ff.tick_cnt == TICK_LAST;
    nxt_st.tick_cnt = tick ? 20'h0 : 20'(st_ff.tick_cnt + 20'h1);
    if (tick) begin
      nxt_st.blink = ~st_ff.blink;
    end
    // heartbeat halts when the control logic reports a fault
    if (!ctrl_ok_in) begin
      nxt_st.hb = 1'b0; // R15
      nxt_st.hb_cnt = 3'h0;
    end else if (tick) begin
      if (st_ff.hb_cnt == 3'(lpd_pkg::HB_HALF_TICKS - 3'h1)) begin
        nxt_st.hb_cnt = 3'h0;
        nxt_st.hb = ~st_ff.hb; // R15
      end else begin
        nxt_st.hb_cnt = 3'(st_ff.hb_cnt + 3'h1);
      end
    end

    // flash stretchers for short events
    for (int c = 0; c < NP; c++) begin
      nxt_st.pz_fl[c] = flash(st_ff.pz_det[c], tick, st_ff.pz_fl[c]); // R13
      pz_led[c] = st_ff.pz_fl[c] != 2'h0;
    end
    for (int j = 0; j < NN; j++) begin
      nxt_st.vv_fl[j] = flash(vehicle_sent_in[j], tick, st_ff.vv_fl[j]); // R14
    end
    nxt_st.rx_fl = flash(rx_msg_in, tick, st_ff.rx_fl); // R16
    nxt_st.tx_fl = flash(tx_msg_in, tick, st_ff.tx_fl); // R16

    // loop view: fault blinks, otherwise follows actuation
    for (int i = 0; i < NL; i++) begin
      loop_led[i] = fault[i] ? st_ff.blink : st_ff.act[i]; // R12
    end

    // indicator mapping by configuration
    nxt_st.leds.power_indicator = 1'b1;
    nxt_st.leds.heartbeat_indicator = st_ff.hb;
    nxt_st.leds.rx_indicator = st_ff.rx_fl != 2'h0;
    nxt_st.leds.tx_indicator = st_ff.tx_fl != 2'h0;
    for (int j = 0; j < NN; j++) begin
      case (sensor_cfg_in)
        lpd_pkg::CFG_LL, lpd_pkg::CFG_PP: nxt_st.leds.lane_indicators[j] = st_ff.vv_fl[j] != 2'h0; // R11
        lpd_pkg::CFG_LPL, lpd_pkg::CFG_LPPL: nxt_st.leds.lane_indicators[j] = pz_led[2*j]; // R11
        lpd_pkg::CFG_PLP: nxt_st.leds.lane_indicators[j] = loop_led[2*j]; // R11
        default: nxt_st.leds.lane_indicators[j] = 1'b0;
      endcase
      // either healthy loop of the pair keeps the lane measured
      nxt_st.lane_occ[j] = (st_ff.act[2*j] & ~fault[2*j]) | (st_ff.act[2*j+1] & ~fault[2*j+1]); // R17
      nxt_st.lane_ok[j] = ~(fault[2*j] & fault[2*j+1]); // R17
    end
    case (sensor_cfg_in)
      lpd_pkg::CFG_PP, lpd_pkg::CFG_PLP: nxt_st.leds.sensor_indicators = pz_led; // R11
      default: nxt_st.leds.sensor_indicators = loop_led; // R11
    endcase
  end

  // state register; power-up starts with a retune
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.retuning <= 1'b1;
      st_ff.scan <= lpd_pkg::SC_IDLE;
      st_ff.cur <= 3'h7;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign loop_sel_out = st_ff.sel;
  assign loop_act_out = st_ff.act;
  assign loop_open_out = st_ff.s2.open_ckt;
  assign loop_short_out = st_ff.s2.short_ckt;
  assign retuning_out = st_ff.retuning;
  assign piezo_det_out = st_ff.pz_det;
  assign lane_occ_out = st_ff.lane_occ;
  assign lane_ok_out = st_ff.lane_ok;
  assign leds_out = st_ff.leds;

endmodule : lpd_top
